// ===== arc_ctrl.sv
// Purpose: Own bus address, soft resets and output behaviour control
// Assumes: Register access arrives as decoded byte requests from the bus slave
// Notes:   Strap sampled at reset release and on full soft reset
`timescale 1ns/1ns
`include "arc_params.svh"
module arc_ctrl
  import arc_pkg::*;
(
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire arc_reg_req_t reg_req,
  input  wire logic [6:0]   address_strap_pin,
  input  wire logic         link_locked,
  output logic [7:0]        reg_rdata,
  output logic [6:0]        active_bus_address,
  output arc_out_ctrl_t     out_ctrl,
  output logic              logic_reset,
  output logic              regs_reset
);

  logic [7:0]     addr_reg;
  logic [7:0]     reset_reg;
  logic [7:0]     cfg_reg;
  logic [7:0]     mem_rdata;
  logic           started;
  logic           next_started;
  logic           reload;
  logic           sc_clear;
  logic [1:0]     cnt;
  logic [1:0]     next_cnt;
  arc_rst_state_t state;
  arc_rst_state_t next_state;
  logic [6:0]     next_active_bus_address;
  arc_out_ctrl_t  next_out_ctrl;
  logic           next_logic_reset;
  logic           next_regs_reset;

  localparam logic [1:0] RST_CYCLES = 2'(`ARC_SOFT_RESET_CYCLES);

  // Effective value: programmed when override set, else forced high
  function automatic logic eff_bit(input logic ovr, input logic val);
    eff_bit = ovr ? val : 1'b1;
  endfunction : eff_bit

  // Strap caught on the first clock after reset, never under the async reset
  assign reload = !started || (state == ARC_FULL_RST && cnt == 2'd0);
  assign sc_clear = (state != ARC_RUN) && (cnt == RST_CYCLES - 2'd1);

  arc_regmem u_mem (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .req        (reg_req),
    .reload     (reload),
    .strap_addr (address_strap_pin),
    .sc_clear   (sc_clear),
    .addr_reg   (addr_reg),
    .reset_reg  (reset_reg),
    .cfg_reg    (cfg_reg),
    .rdata      (mem_rdata)
  );

  always_comb begin
    next_started = 1'b1;
    next_state   = state;
    next_cnt     = cnt;
    unique case (state)
      ARC_RUN: begin
        next_cnt = 2'd0;
        // Full reset takes priority when both bits are written
        if (reset_reg[`ARC_BIT_FULL_LOGIC_RESET]) begin
          next_state = ARC_FULL_RST;
        end else if (reset_reg[`ARC_BIT_LOGIC_RESET_KEEP]) begin
          next_state = ARC_KEEP_RST;
        end
      end
      ARC_FULL_RST, ARC_KEEP_RST: begin
        if (cnt == RST_CYCLES - 2'd1) begin
          next_state = ARC_RUN;
        end else begin
          next_cnt = cnt + 2'd1;
        end
      end
    endcase
  end

  always_comb begin
    next_logic_reset = (next_state != ARC_RUN);
    next_regs_reset  = (next_state == ARC_FULL_RST);
    // Source select: strap address or programmed field
    next_active_bus_address = addr_reg[`ARC_BIT_ADDR_SRC_SEL] ? addr_reg[7:1]
                                                              : address_strap_pin;
    next_out_ctrl.output_enable = eff_bit(cfg_reg[`ARC_BIT_OVERRIDE_ON],
                                          cfg_reg[`ARC_BIT_OUTPUT_ENABLE]);
    next_out_ctrl.unlocked_state_sel = eff_bit(cfg_reg[`ARC_BIT_OVERRIDE_ON],
                                               cfg_reg[`ARC_BIT_SLEEP_SEL]);
    // Frequency choice lives in a separate register outside this block
    next_out_ctrl.fallback_clk_sel = cfg_reg[`ARC_BIT_FALLBACK_CLK_ON]
                                     && !link_locked;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      started            <= 1'b0;
      state              <= ARC_RUN;
      cnt                <= 2'd0;
      logic_reset        <= 1'b0;
      regs_reset         <= 1'b0;
      active_bus_address <= 7'h00;
      out_ctrl           <= '{output_enable: 1'b1, unlocked_state_sel: 1'b1,
                              fallback_clk_sel: 1'b0};
      reg_rdata          <= 8'h00;
    end else begin
      started            <= next_started;
      state              <= next_state;
      cnt                <= next_cnt;
      logic_reset        <= next_logic_reset;
      regs_reset         <= next_regs_reset;
      active_bus_address <= next_active_bus_address;
      out_ctrl           <= next_out_ctrl;
      reg_rdata          <= mem_rdata;
    end
  end

endmodule : arc_ctrl

// ===== arc_params.svh
// Purpose: Offsets, field positions, reset values and timing for the address/reset/output block
// Assumes: 8-bit register data, 8-bit register offsets
// Notes:   Included by the design modules arc_ctrl and arc_regmem, not by the package
`ifndef ARC_PARAMS_SVH
`define ARC_PARAMS_SVH

`define ARC_OFS_OWN_BUS_ADDRESS      8'h00
`define ARC_OFS_SOFT_RESET_CONTROL   8'h01
`define ARC_OFS_OUTPUT_BEHAV_CONFIG  8'h02

`define ARC_BIT_ADDR_SRC_SEL         0
`define ARC_BIT_LOGIC_RESET_KEEP    0
`define ARC_BIT_FULL_LOGIC_RESET     1
`define ARC_BIT_SLEEP_SEL            4
`define ARC_BIT_FALLBACK_CLK_ON      5
`define ARC_BIT_OVERRIDE_ON          6
`define ARC_BIT_OUTPUT_ENABLE        7

`define ARC_RST_SOFT_RESET_CONTROL   8'h04
`define ARC_RST_OUTPUT_BEHAV_CONFIG  8'h80
`define ARC_SC_MASK                  8'h03

`define ARC_SOFT_RESET_NS            100
`define ARC_CLK_PERIOD_NS            50
`define ARC_SOFT_RESET_CYCLES \
  ((`ARC_SOFT_RESET_NS + `ARC_CLK_PERIOD_NS - 1) / `ARC_CLK_PERIOD_NS)

`endif

// ===== arc_pkg.sv
// Purpose: Types shared by the address/reset/output block
// Assumes: Parameters header holds all numbers
// Notes:   Structs carry grouped signals
package arc_pkg;

  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } arc_reg_req_t;

  typedef struct packed {
    logic output_enable;
    logic unlocked_state_sel;
    logic fallback_clk_sel;
  } arc_out_ctrl_t;

  typedef enum logic [1:0] {
    ARC_RUN,
    ARC_FULL_RST,
    ARC_KEEP_RST
  } arc_rst_state_t;

endpackage : arc_pkg

// ===== arc_regmem.sv
// Purpose: Storage of the three control bytes with registered read data
// Assumes: One access per cycle; a read in the same cycle as a write returns the old value
// Notes:   Strap reload comes through the reload strobe
`timescale 1ns/1ns
`include "arc_params.svh"
module arc_regmem
  import arc_pkg::*;
(
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire arc_reg_req_t req,
  input  wire logic         reload,
  input  wire logic [6:0]   strap_addr,
  input  wire logic         sc_clear,
  output logic [7:0]        addr_reg,
  output logic [7:0]        reset_reg,
  output logic [7:0]        cfg_reg,
  output logic [7:0]        rdata
);

  logic [7:0] next_addr_reg;
  logic [7:0] next_reset_reg;
  logic [7:0] next_cfg_reg;
  logic [7:0] next_rdata;

  always_comb begin
    next_addr_reg  = addr_reg;
    next_reset_reg = reset_reg;
    next_cfg_reg   = cfg_reg;
    next_rdata     = rdata;
    if (sc_clear) begin
      next_reset_reg = reset_reg & ~`ARC_SC_MASK;
    end
    if (req.wr_en) begin
      unique case (req.addr)
        `ARC_OFS_OWN_BUS_ADDRESS:     next_addr_reg  = req.wdata;
        `ARC_OFS_SOFT_RESET_CONTROL:  next_reset_reg = req.wdata;
        `ARC_OFS_OUTPUT_BEHAV_CONFIG: next_cfg_reg   = req.wdata;
        default: ;
      endcase
    end
    if (reload) begin
      // Full reset restores strap value and all defaults
      next_addr_reg  = {strap_addr, 1'b0};
      next_reset_reg = `ARC_RST_SOFT_RESET_CONTROL;
      next_cfg_reg   = `ARC_RST_OUTPUT_BEHAV_CONFIG;
    end
    if (req.rd_en) begin
      unique case (req.addr)
        `ARC_OFS_OWN_BUS_ADDRESS:     next_rdata = addr_reg;
        `ARC_OFS_SOFT_RESET_CONTROL:  next_rdata = reset_reg;
        `ARC_OFS_OUTPUT_BEHAV_CONFIG: next_rdata = cfg_reg;
        default:                      next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      addr_reg  <= 8'h00;
      reset_reg <= `ARC_RST_SOFT_RESET_CONTROL;
      cfg_reg   <= `ARC_RST_OUTPUT_BEHAV_CONFIG;
      rdata     <= 8'h00;
    end else begin
      addr_reg  <= next_addr_reg;
      reset_reg <= next_reset_reg;
      cfg_reg   <= next_cfg_reg;
      rdata     <= next_rdata;
    end
  end

endmodule : arc_regmem

// ===== arc_ctrl_assertions.sv
// Purpose: Port checks for the address/reset/output block
// Assumes: Derived outputs settle two edges after a write
// Notes:   Back-to-back soft resets are not covered
`timescale 1ns/1ns
module arc_ctrl_chk
  import arc_pkg::*;
(
  input wire logic         sys_clk,
  input wire logic         rst,
  input wire arc_reg_req_t reg_req,
  input wire logic [6:0]   address_strap_pin,
  input wire logic         link_locked,
  input wire logic [6:0]   active_bus_address,
  input wire arc_out_ctrl_t out_ctrl,
  input wire logic         logic_reset,
  input wire logic         regs_reset
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_wr(a); reg_req.wr_en && reg_req.addr == a; endsequence
  sequence s_full;
    reg_req.wr_en && reg_req.addr == 8'h01 && reg_req.wdata[1];
  endsequence
  sequence s_keep;
    reg_req.wr_en && reg_req.addr == 8'h01 && reg_req.wdata[1:0] == 2'b01;
  endsequence
  property p_oe; logic [7:0] d;
    (s_wr(8'h02), d = reg_req.wdata) |-> ##2 out_ctrl.output_enable == (d[6] ? d[7] : 1'b1);
  endproperty
  a_oe: assert property (p_oe) else $error("output enable wrong");
  property p_sleep; logic [7:0] d;
    (s_wr(8'h02), d = reg_req.wdata) |-> ##2 out_ctrl.unlocked_state_sel == (d[6] ? d[4] : 1'b1);
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep select wrong");
  property p_fallback; logic [7:0] d;
    (s_wr(8'h02), d = reg_req.wdata) ##1 !link_locked |=> out_ctrl.fallback_clk_sel == d[5];
  endproperty
  a_fallback: assert property (p_fallback) else $error("fallback clock wrong");
  property p_logic_pulse;
    (s_full or s_keep) |-> ##2 logic_reset [*2] ##1 !logic_reset;
  endproperty
  a_logic_pulse: assert property (p_logic_pulse) else $error("logic reset pulse wrong");
  property p_regs_pulse; s_full |-> ##2 regs_reset [*2] ##1 !regs_reset; endproperty
  a_regs_pulse: assert property (p_regs_pulse) else $error("register reset pulse wrong");
  property p_keep_regs; s_keep |-> ##1 !regs_reset [*4]; endproperty
  a_keep_regs: assert property (p_keep_regs) else $error("keep reset touched registers");
  property p_addr; logic [7:0] d;
    (s_wr(8'h00), d = reg_req.wdata) |-> ##2
      active_bus_address == (d[0] ? d[7:1] : address_strap_pin);
  endproperty
  a_addr: assert property (p_addr) else $error("active address wrong");
  property p_reload; $fell(regs_reset) |=> active_bus_address == address_strap_pin; endproperty
  a_reload: assert property (p_reload) else $error("strap not restored");
endmodule : arc_ctrl_chk
bind arc_ctrl arc_ctrl_chk u_chk (.sys_clk, .rst, .reg_req, .address_strap_pin, .link_locked,
  .active_bus_address, .out_ctrl, .logic_reset, .regs_reset);

// ===== arc_host_model.sv
// Purpose: Register host issuing single byte accesses
// Assumes: Requests launched on falling edges
// Notes:   Released data is inverted so stale values cannot pass
`timescale 1ns/1ns
module arc_host_model
  import arc_pkg::*;
(
  input  wire logic   sys_clk,
  output arc_reg_req_t reg_req
);
  initial reg_req = '0;
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_req = '{w, !w, a, d};
    @(negedge sys_clk);
    reg_req = '{1'b0, 1'b0, a, ~d};
  endtask : xfer
endmodule : arc_host_model

// ===== tb_top.sv
// Purpose: Self-checking bench for the address/reset/output block
// Assumes: Read data valid after two edges
// Notes:   Strap held static
`timescale 1ns/1ns
module tb_top;
  import arc_pkg::*;
  logic          sys_clk = 0, rst = 1, link_locked = 1, logic_reset, regs_reset;
  logic [6:0]    strap = 7'h2A, active_bus_address;
  logic [7:0]    reg_rdata;
  arc_reg_req_t  reg_req;
  arc_out_ctrl_t out_ctrl;
  int            failures = 0, compares = 0;
  logic [7:0]    cv [6] = '{8'h20, 8'hE0, 8'h50, 8'h00, 8'h40, 8'hC0};
  always #25 sys_clk = ~sys_clk;
  arc_host_model u_host (.sys_clk(sys_clk), .reg_req(reg_req));
  arc_ctrl u_dut (.sys_clk(sys_clk), .rst(rst), .reg_req(reg_req), .address_strap_pin(strap),
    .link_locked(link_locked), .reg_rdata(reg_rdata), .active_bus_address(active_bus_address),
    .out_ctrl(out_ctrl), .logic_reset(logic_reset), .regs_reset(regs_reset));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    u_host.xfer(1'b0, a, 8'h00);
    repeat (2) @(negedge sys_clk);
    chk(reg_rdata, exp);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host.xfer(1'b1, a, d);
    @(negedge sys_clk);
  endtask : wr
  task automatic end_of_test;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test
  initial begin
    #100000;
    failures++;
    end_of_test();
  end
  initial begin
    repeat (5) @(negedge sys_clk);
    rst = 0;
    repeat (3) @(negedge sys_clk);
    rd(8'h00, {strap, 1'b0});
    rd(8'h01, 8'h04);
    rd(8'h02, 8'h80);
    rd(8'h07, 8'h00);
    wr(8'h00, 8'hA5);
    chk({1'b0, active_bus_address}, 8'h52);
    rd(8'h00, 8'hA5);
    foreach (cv[i]) begin
      link_locked = i[0];
      wr(8'h02, cv[i]);
      chk({5'h0, out_ctrl}, {5'h0, cv[i][6] ? cv[i][7] : 1'b1, cv[i][6] ? cv[i][4] : 1'b1,
        cv[i][5] & !link_locked});
    end
    // Bit 2 written back high so the reserved default survives
    wr(8'h01, 8'h05);
    chk({logic_reset, regs_reset, 6'h0}, 8'h80);
    @(negedge sys_clk);
    chk({logic_reset, regs_reset, 6'h0}, 8'h80);
    @(negedge sys_clk);
    chk({logic_reset, regs_reset, 6'h0}, 8'h00);
    rd(8'h01, 8'h04);
    rd(8'h02, 8'hC0);
    wr(8'h01, 8'h02);
    chk({logic_reset, regs_reset, 6'h0}, 8'hC0);
    @(negedge sys_clk);
    chk({logic_reset, regs_reset, 6'h0}, 8'hC0);
    @(negedge sys_clk);
    chk({logic_reset, regs_reset, 6'h0}, 8'h00);
    rd(8'h01, 8'h04);
    rd(8'h02, 8'h80);
    rd(8'h00, {strap, 1'b0});
    chk({1'b0, active_bus_address}, {1'b0, strap});
    end_of_test();
  end
endmodule : tb_top
